// file: core/bbg_node.sv
// Board bus glue, nibble status bus slave and serial ring node
`timescale 1ns/100ps
`default_nettype none
module bbg_node (
  input wire logic core_clk,                  // Core clock, 200 MHz
  input wire logic rst,                       // Asynchronous reset, active high
  input wire logic bus_clock,                 // Processor bus clock pin
  input wire logic bus_read,                  // Direction pin, high for read
  input wire logic address_latch_strobe,      // Address strobe pin
  input wire logic [7:0] ad_lines,            // Multiplexed low address/data pins
  input wire logic [7:0] addr_hi,             // High address pins
  output logic [7:0] addr_lo,                 // Demultiplexed low address
  output logic [7:0] data_lo,                 // Data captured in data phase
  output logic mem_oe_n,                      // Memory output enable, active low
  output logic rom_ce_n,                      // Program memory chip enable, active low
  output logic ram_ce_n,                      // Working memory chip enable, active low
  output logic ram_we_n,                      // Working memory write enable, active low
  output logic io_cs_n,                       // Peripheral chip select, active low
  input wire logic nibble_strobe_n,           // Nibble bus data strobe
  input wire logic [3:0] nibble_index_lines,  // Nibble index from master
  input wire logic [3:0] nibble_value_lines_n,// Nibble data, active low
  output logic [63:0] nibble_image,           // All captured nibbles
  output logic nibble_service_irq_n,          // Interrupt per index step, active low
  input wire logic irq_ack,                   // Clears the interrupt, one pulse
  input wire logic ring_bit_clock,            // Ring clock from master
  input wire logic ring_frame_sync,           // Packet sync, first bit
  input wire logic ring_return_input,         // Ring data from upstream node
  output logic ring_master_output,            // Ring data back to master
  input wire logic [7:0] ring_own_bits,       // Bits this node sends
  input wire logic ring_own_load,             // Load pulse for ring_own_bits
  output logic [39:0] ring_image,             // Last complete packet
  input wire logic serial_tx,                 // Async port transmit data
  output logic serial_rx,                     // Async port receive data
  input wire logic shared_line_in,            // Shared serial line level
  output logic shared_line_out,               // Shared serial line drive value
  output logic shared_line_oe                 // High while pulling the line low
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [bbg_pkg::PIN_W-1:0] pin_s1_ff;
  logic [bbg_pkg::PIN_W-1:0] pin_s2_ff;
  wire [bbg_pkg::PIN_W-1:0] pin_raw = {bus_clock, bus_read, address_latch_strobe, ad_lines, addr_hi,
    nibble_strobe_n, nibble_index_lines, nibble_value_lines_n};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      // Strobe resets to its idle level, so no false fall follows reset
      pin_s1_ff <= bbg_pkg::PIN_IDLE;
      pin_s2_ff <= bbg_pkg::PIN_IDLE;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire e_s = pin_s2_ff[27];
  wire rw_s = pin_s2_ff[26];
  wire as_s = pin_s2_ff[25];
  wire [7:0] ad_s = pin_s2_ff[24:17];
  wire [7:0] hi_s = pin_s2_ff[16:9];
  wire strobe_n_s = pin_s2_ff[8];
  wire [3:0] idx_s = pin_s2_ff[7:4];
  wire [3:0] val_n_s = pin_s2_ff[3:0];

  // ----------------------------------------------------------------
  // Address demultiplex and decode
  // ----------------------------------------------------------------
  logic [7:0] addr_lo_ff;
  logic [7:0] data_lo_ff;
  logic mem_oe_n_ff;
  logic rom_ce_n_ff;
  logic ram_ce_n_ff;
  logic ram_we_n_ff;
  logic io_cs_n_ff;
  wire [15:0] full_addr = {hi_s, addr_lo_ff};
  wire rom_hit = full_addr[15 -: bbg_pkg::ROM_TOP_W] == bbg_pkg::ROM_TOP;
  wire ram_hit = full_addr[15 -: bbg_pkg::RAM_TOP_W] == bbg_pkg::RAM_TOP;
  wire io_hit = full_addr[15 -: bbg_pkg::IO_TOP_W] == bbg_pkg::IO_TOP;
  wire rd_cycle = e_s & rw_s;
  wire wr_cycle = e_s & ~rw_s;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_lo_ff <= 8'h00;
      data_lo_ff <= 8'h00;
      mem_oe_n_ff <= 1'h1;
      rom_ce_n_ff <= 1'h1;
      ram_ce_n_ff <= 1'h1;
      ram_we_n_ff <= 1'h1;
      io_cs_n_ff <= 1'h1;
    end else begin
      if (as_s) begin
        addr_lo_ff <= ad_s;
      end
      if (!as_s && e_s) begin
        data_lo_ff <= ad_s;
      end
      mem_oe_n_ff <= ~rd_cycle;
      rom_ce_n_ff <= ~rom_hit;
      ram_ce_n_ff <= ~ram_hit;
      ram_we_n_ff <= ~wr_cycle;
      io_cs_n_ff <= ~io_hit;
    end
  end
  assign addr_lo = addr_lo_ff;
  assign data_lo = data_lo_ff;
  assign mem_oe_n = mem_oe_n_ff;
  assign rom_ce_n = rom_ce_n_ff;
  assign ram_ce_n = ram_ce_n_ff;
  assign ram_we_n = ram_we_n_ff;
  assign io_cs_n = io_cs_n_ff;

  a_addr_latch: assert property (@(posedge core_clk) disable iff (rst) as_s |=> addr_lo_ff == $past(ad_s))
    else $error("low address not latched while strobe high");
  a_addr_hold: assert property (@(posedge core_clk) disable iff (rst) !as_s |=> $stable(addr_lo_ff))
    else $error("latched low address changed in data phase");
  a_oe_read: assert property (@(posedge core_clk) disable iff (rst) rd_cycle |=> !mem_oe_n_ff)
    else $error("output enable not low in read cycle");
  a_we_write: assert property (@(posedge core_clk) disable iff (rst) wr_cycle |=> !ram_we_n_ff && mem_oe_n_ff)
    else $error("write enable not low in write cycle");
  a_rom_select: assert property (@(posedge core_clk) disable iff (rst) rom_ce_n_ff == !$past(rom_hit))
    else $error("program chip enable does not follow decode");
  a_ram_select: assert property (@(posedge core_clk) disable iff (rst) ram_ce_n_ff == !$past(ram_hit))
    else $error("working memory select does not follow decode");
  a_io_select: assert property (@(posedge core_clk) disable iff (rst) io_cs_n_ff == !$past(io_hit))
    else $error("peripheral select does not follow decode");
  a_cs_onehot: assert property (@(posedge core_clk) disable iff (rst)
    $onehot0({~rom_ce_n_ff, ~ram_ce_n_ff, ~io_cs_n_ff}))
    else $error("more than one chip select active");
  a_data_capture: assert property (@(posedge core_clk) disable iff (rst)
    !as_s && e_s |=> data_lo_ff == $past(ad_s))
    else $error("data not captured in data phase");
  a_strobe_idle: assert property (@(posedge core_clk) disable iff (rst)
    !e_s |=> mem_oe_n_ff && ram_we_n_ff)
    else $error("memory strobe active with bus clock low");

  // ----------------------------------------------------------------
  // Nibble status bus slave
  // ----------------------------------------------------------------
  logic [3:0] nib_ff [bbg_pkg::NIB_CNT];
  logic strobe_n_d_ff;
  logic [3:0] idx_d_ff;
  logic irq_ff;
  wire strobe_fall = strobe_n_d_ff & ~strobe_n_s;
  wire idx_step = idx_s != idx_d_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < bbg_pkg::NIB_CNT; i++) begin
        nib_ff[i] <= 4'h0;
      end
      strobe_n_d_ff <= 1'h1;
      idx_d_ff <= 4'h0;
      irq_ff <= 1'h0;
    end else begin
      strobe_n_d_ff <= strobe_n_s;
      idx_d_ff <= idx_s;
      if (strobe_fall) begin
        nib_ff[idx_s] <= ~val_n_s;
      end
      irq_ff <= idx_step | (irq_ff & ~irq_ack);
    end
  end
  generate
    for (genvar g = 0; g < bbg_pkg::NIB_CNT; g++) begin : g_nib
      assign nibble_image[g*bbg_pkg::NIB_W +: bbg_pkg::NIB_W] = nib_ff[g];
    end
  endgenerate
  assign nibble_service_irq_n = ~irq_ff;

  a_nib_store: assert property (@(posedge core_clk) disable iff (rst)
    strobe_fall |=> nib_ff[$past(idx_s)] == $past(~val_n_s))
    else $error("nibble not stored at its index");
  a_irq_ack: assert property (@(posedge core_clk) disable iff (rst) irq_ack && !idx_step |=> nibble_service_irq_n)
    else $error("interrupt not cleared by acknowledge");
  a_irq_step: assert property (@(posedge core_clk) disable iff (rst) idx_step |=> !nibble_service_irq_n)
    else $error("no interrupt after index step");
  a_irq_hold: assert property (@(posedge core_clk) disable iff (rst) irq_ff && !irq_ack && !idx_step |=> irq_ff)
    else $error("interrupt dropped without acknowledge");

  // ----------------------------------------------------------------
  // Core side of ring crossings
  // ----------------------------------------------------------------
  logic [7:0] own_word_ff;
  logic own_tgl_ff;
  logic [2:0] pkt_tgl_s_ff;
  logic [39:0] ring_image_ff;
  logic [39:0] pkt_word_ff;
  logic pkt_tgl_ff;
  wire pkt_new = pkt_tgl_s_ff[2] ^ pkt_tgl_s_ff[1];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      own_word_ff <= 8'h00;
      own_tgl_ff <= 1'h0;
      pkt_tgl_s_ff <= 3'h0;
      ring_image_ff <= '0;
    end else begin
      if (ring_own_load) begin
        own_word_ff <= ring_own_bits;
        own_tgl_ff <= ~own_tgl_ff;
      end
      pkt_tgl_s_ff <= {pkt_tgl_s_ff[1:0], pkt_tgl_ff};
      if (pkt_new) begin
        ring_image_ff <= pkt_word_ff;
      end
    end
  end
  assign ring_image = ring_image_ff;

  a_image_load: assert property (@(posedge core_clk) disable iff (rst)
    pkt_new |=> ring_image_ff == $past(pkt_word_ff))
    else $error("ring image not loaded from finished packet");

  // ----------------------------------------------------------------
  // Ring node on the ring clock
  // ----------------------------------------------------------------
  logic [1:0] ring_rst_ff;
  logic [5:0] bit_cnt_ff;
  logic [39:0] rx_ff;
  logic [7:0] own_ring_ff;
  logic [2:0] own_tgl_s_ff;
  logic ring_out_ff;
  wire ring_rst = ring_rst_ff[1];
  wire [5:0] pos = ring_frame_sync ? 6'h00 : bit_cnt_ff;
  wire own_pos = pos >= bbg_pkg::OWN_FIRST;
  wire [5:0] own_idx = pos - bbg_pkg::OWN_FIRST;
  wire own_bit = own_ring_ff[own_idx[2:0]];
  always_ff @(posedge ring_bit_clock or posedge rst) begin
    if (rst) begin
      ring_rst_ff <= 2'h3;
    end else begin
      ring_rst_ff <= {ring_rst_ff[0], 1'h0};
    end
  end
  always_ff @(posedge ring_bit_clock or posedge ring_rst) begin
    if (ring_rst) begin
      bit_cnt_ff <= 6'h00;
      rx_ff <= '0;
      pkt_word_ff <= '0;
      pkt_tgl_ff <= 1'h0;
      own_ring_ff <= 8'h00;
      own_tgl_s_ff <= 3'h0;
      ring_out_ff <= 1'h1;
    end else begin
      bit_cnt_ff <= (pos == bbg_pkg::RING_LAST) ? 6'h00 : pos + bbg_pkg::RING_SECOND;
      rx_ff[pos] <= ring_return_input;
      if (pos == bbg_pkg::RING_LAST) begin
        pkt_word_ff <= {ring_return_input, rx_ff[38:0]};
        pkt_tgl_ff <= ~pkt_tgl_ff;
      end
      own_tgl_s_ff <= {own_tgl_s_ff[1:0], own_tgl_ff};
      if (own_tgl_s_ff[2] ^ own_tgl_s_ff[1]) begin
        own_ring_ff <= own_word_ff;
      end
      ring_out_ff <= own_pos ? own_bit : ring_return_input;
    end
  end
  assign ring_master_output = ring_out_ff;

  a_ring_pass: assert property (@(posedge ring_bit_clock) disable iff (ring_rst)
    !own_pos |=> ring_master_output == $past(ring_return_input))
    else $error("foreign ring bit altered");
  a_own_insert: assert property (@(posedge ring_bit_clock) disable iff (ring_rst)
    own_pos |=> ring_master_output == $past(own_bit))
    else $error("own ring bit not inserted");
  a_ring_sync: assert property (@(posedge ring_bit_clock) disable iff (ring_rst)
    ring_frame_sync |=> bit_cnt_ff == 6'h01)
    else $error("bit count not aligned to sync");
  a_ring_wrap: assert property (@(posedge ring_bit_clock) disable iff (ring_rst)
    pos == 6'h27 |=> bit_cnt_ff == 6'h00 && pkt_tgl_ff != $past(pkt_tgl_ff))
    else $error("packet not closed at bit 39");

  // ----------------------------------------------------------------
  // Shared serial line, open drain
  // ----------------------------------------------------------------
  logic [1:0] line_s_ff;
  logic [1:0] tx_s_ff;
  // Transmit pin is synchronised too; the line is only ever pulled low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_s_ff <= 2'h3;
      tx_s_ff <= 2'h3;
    end else begin
      line_s_ff <= {line_s_ff[0], shared_line_in};
      tx_s_ff <= {tx_s_ff[0], serial_tx};
    end
  end
  assign shared_line_out = 1'h0;
  assign shared_line_oe = ~tx_s_ff[1];
  assign serial_rx = line_s_ff[1];
endmodule : bbg_node
`default_nettype wire

// file: core/bbg_pkg.sv
// Constants for the board bus glue and ring node
package bbg_pkg;
  // ----------------------------------------------------------------
  // Address decode regions (upper address bits that select a region)
  // ----------------------------------------------------------------
  localparam int ROM_TOP_W = 1;
  localparam logic [0:0] ROM_TOP = 1'h1;    // 0x8000-0xFFFF program memory
  localparam int RAM_TOP_W = 3;
  localparam logic [2:0] RAM_TOP = 3'h1;    // 0x2000-0x3FFF working memory
  localparam int IO_TOP_W = 4;
  localparam logic [3:0] IO_TOP = 4'h1;     // 0x1000-0x1FFF peripheral block
  // ----------------------------------------------------------------
  // Nibble status bus
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int NIB_CNT = 16;
  localparam int NIB_BITS = 64;
  // ----------------------------------------------------------------
  // Serial ring packet layout
  // ----------------------------------------------------------------
  localparam int RING_BITS = 40;
  localparam int OWN_BITS = 8;
  localparam logic [5:0] OWN_FIRST = 6'h20;  // Positions 32..39 belong to this node
  localparam logic [5:0] RING_LAST = 6'h27;  // Position 39
  localparam logic [5:0] RING_SECOND = 6'h01;
  // ----------------------------------------------------------------
  // Pin synchroniser bundle width
  // ----------------------------------------------------------------
  localparam int PIN_W = 28;
  // Synchroniser reset image: the nibble strobe pin idles high
  localparam logic [27:0] PIN_IDLE = 28'h0000100;
endpackage : bbg_pkg

// file: tb/bbg_ring_master.sv
// Ring master model: frames the ring clock, sync and upstream data
`timescale 1ns/100ps
`default_nettype none
module bbg_ring_master (
  output logic ring_bit_clock,         // Ring clock, also pulsed with sync low between frames
  output logic ring_frame_sync,        // High for the first bit only
  output logic ring_return_input,      // Upstream node data
  input wire logic ring_master_output  // Node output back to master
);
  initial begin
    ring_bit_clock = 1'b0;
    ring_frame_sync = 1'b0;
    ring_return_input = 1'b0;
  end
  // Clocks n edges with sync low and data toggling
  task automatic idle(input int n);
    repeat (n) begin
      ring_return_input = ~ring_return_input;
      #15 ring_bit_clock = 1'b1;
      #15 ring_bit_clock = 1'b0;
    end
  endtask : idle
  // Sends one packet; got[p] is the node output for position p
  task automatic frame(input logic [39:0] pkt, output logic [39:0] got);
    idle(2);
    for (int k = 0; k <= 40; k++) begin
      if (k > 0) got[k-1] = ring_master_output;
      ring_frame_sync = (k == 0);
      ring_return_input = (k < 40) ? pkt[k] : ~ring_return_input;
      #15 ring_bit_clock = 1'b1;
      #15 ring_bit_clock = 1'b0;
    end
    ring_frame_sync = 1'b0;
  endtask : frame
endmodule : bbg_ring_master
`default_nettype wire

// file: tb/test_board_bus_glue_and_ring_node.sv
// Self-checking bench for the board bus glue and ring node
`timescale 1ns/100ps
`default_nettype none
module test_board_bus_glue_and_ring_node;
  logic core_clk, rst, bus_clock, bus_read, address_latch_strobe, nibble_strobe_n, irq_ack;
  logic [7:0] ad_lines, addr_hi, addr_lo, data_lo, ring_own_bits;
  logic mem_oe_n, rom_ce_n, ram_ce_n, ram_we_n, io_cs_n, nibble_service_irq_n;
  logic [3:0] nibble_index_lines, nibble_value_lines_n;
  logic [63:0] nibble_image;
  logic [39:0] ring_image;
  logic ring_bit_clock, ring_frame_sync, ring_return_input, ring_master_output, ring_own_load;
  logic serial_tx, serial_rx, shared_line_out, shared_line_oe;
  wire logic line = shared_line_oe ? shared_line_out : 1'b1;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  bbg_node i_dut (.core_clk(core_clk), .rst(rst), .bus_clock(bus_clock), .bus_read(bus_read),
    .address_latch_strobe(address_latch_strobe), .ad_lines(ad_lines), .addr_hi(addr_hi), .addr_lo(addr_lo),
    .data_lo(data_lo), .mem_oe_n(mem_oe_n), .rom_ce_n(rom_ce_n), .ram_ce_n(ram_ce_n), .ram_we_n(ram_we_n),
    .io_cs_n(io_cs_n), .nibble_strobe_n(nibble_strobe_n), .nibble_index_lines(nibble_index_lines),
    .nibble_value_lines_n(nibble_value_lines_n), .nibble_image(nibble_image),
    .nibble_service_irq_n(nibble_service_irq_n), .irq_ack(irq_ack), .ring_bit_clock(ring_bit_clock),
    .ring_frame_sync(ring_frame_sync), .ring_return_input(ring_return_input),
    .ring_master_output(ring_master_output), .ring_own_bits(ring_own_bits), .ring_own_load(ring_own_load),
    .ring_image(ring_image), .serial_tx(serial_tx), .serial_rx(serial_rx), .shared_line_in(line),
    .shared_line_out(shared_line_out), .shared_line_oe(shared_line_oe));
  bbg_ring_master i_ring (.ring_bit_clock(ring_bit_clock), .ring_frame_sync(ring_frame_sync),
    .ring_return_input(ring_return_input), .ring_master_output(ring_master_output));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n
  // ----------------------------------------------------------------
  // Processor bus: address phase, data phase, then bus clock high
  // ----------------------------------------------------------------
  task automatic bus_cycle(input logic [15:0] a, input logic [7:0] d, input logic rd);
    bus_clock = 1'b0;
    address_latch_strobe = 1'b1;
    ad_lines = a[7:0];
    addr_hi = a[15:8];
    wait_n(4);
    address_latch_strobe = 1'b0;
    ad_lines = d;
    wait_n(4);
    chk(addr_lo, a[7:0], "low address not held in data phase");
    chk(rom_ce_n, a[15 -: bbg_pkg::ROM_TOP_W] != bbg_pkg::ROM_TOP, "program enable");
    chk(ram_ce_n, a[15 -: bbg_pkg::RAM_TOP_W] != bbg_pkg::RAM_TOP, "working memory select");
    chk(io_cs_n, a[15 -: bbg_pkg::IO_TOP_W] != bbg_pkg::IO_TOP, "peripheral select");
    chk({mem_oe_n, ram_we_n}, 2'h3, "strobes active with bus clock low");
    bus_read = rd;
    bus_clock = 1'b1;
    wait_n(4);
    chk({mem_oe_n, ram_we_n}, {~rd, rd}, "read or write strobe");
    chk(data_lo, d, "data phase capture");
    bus_clock = 1'b0;
    wait_n(4);
    chk({mem_oe_n, ram_we_n}, 2'h3, "strobes not released");
  endtask : bus_cycle
  task automatic t_decode();
    logic [15:0] tbl [9] = '{16'h8000, 16'hFFFF, 16'h7FFF, 16'h2000, 16'h3FFF, 16'h1FFF, 16'h1000,
      16'h0FFF, 16'h4000};
    for (int i = 0; i < 9; i++) begin
      bus_cycle(tbl[i], tbl[i][15:8] ^ 8'h5A, i[0]);
    end
  endtask : t_decode
  // ----------------------------------------------------------------
  // Nibble bus: every index step, including the wrap to zero
  // ----------------------------------------------------------------
  task automatic t_nibble();
    logic [3:0] v;
    for (int i = 1; i <= 16; i++) begin
      v = i[3:0] ^ 4'hA;
      nibble_index_lines = i[3:0];
      nibble_value_lines_n = ~v;
      wait_n(5);
      chk(nibble_service_irq_n, 1'b0, "no interrupt on index step");
      irq_ack = 1'b1;
      wait_n(1);
      irq_ack = 1'b0;
      wait_n(2);
      chk(nibble_service_irq_n, 1'b1, "interrupt not cleared");
      nibble_strobe_n = 1'b0;
      wait_n(5);
      nibble_strobe_n = 1'b1;
      chk(nibble_image[4*(i%16) +: 4], v, "nibble not captured");
    end
  endtask : t_nibble
  // ----------------------------------------------------------------
  // Ring: passthrough of foreign positions, own positions inserted
  // ----------------------------------------------------------------
  task automatic t_ring(input logic [39:0] pkt, input logic [7:0] own);
    logic [39:0] got;
    ring_own_bits = own;
    ring_own_load = 1'b1;
    wait_n(1);
    ring_own_load = 1'b0;
    i_ring.frame(pkt, got);
    chk(got, {own, pkt[31:0]}, "ring output packet");
    wait_n(10);
    chk(ring_image, pkt, "ring image");
  endtask : t_ring
  task automatic t_shared();
    for (int i = 0; i < 2; i++) begin
      serial_tx = i[0];
      wait_n(6);
      chk({shared_line_oe, serial_rx, line}, {~i[0], i[0], i[0]}, "shared line");
    end
  endtask : t_shared
  initial begin
    {rst, bus_read, address_latch_strobe, nibble_strobe_n, serial_tx} = 5'h1F;
    {bus_clock, irq_ack, ring_own_load} = 3'h0;
    {ad_lines, addr_hi, ring_own_bits} = 24'h0;
    nibble_index_lines = 4'h0;
    nibble_value_lines_n = 4'hF;
    fork
      i_ring.idle(3);
      wait_n(20);
    join
    rst = 1'b0;
    wait_n(4);
    chk({ring_master_output, serial_rx, nibble_service_irq_n, mem_oe_n, ram_we_n}, 5'h1F, "reset levels");
    chk(nibble_image[39:0], 40'h0, "nibble image not clear after reset");
    chk(ring_image, 40'h0, "ring image not clear after reset");
    t_decode();
    t_nibble();
    t_ring(40'hA5_C3F0_1E96, 8'h5A);
    t_ring(40'h3C_0FF0_A55A, 8'h81);
    t_shared();
    print_verdict();
  end
endmodule : test_board_bus_glue_and_ring_node
`default_nettype wire
